// file: inc/throttle_alert_pkg.sv
// package: register map, field layout and timing constants of the throttle alert profile
`default_nettype none
package throttle_alert_pkg;

    // register map (byte addresses on the two-wire port)
    localparam logic [7:0]  REG_SRC_EN_ADDR  = 8'h38;
    localparam logic [7:0]  REG_THR_DEG_ADDR = 8'h39;
    localparam logic [7:0]  SRC_EN_RESET     = 8'h20;
    localparam logic [7:0]  THR_DEG_RESET    = 8'h81;

    // source enable bit positions
    localparam int SRC_COMP_BIT    = 6;
    localparam int SRC_CRIT_BIT    = 5;
    localparam int SRC_NOM_BIT     = 4;
    localparam int SRC_DCHG_BIT    = 3;
    localparam int SRC_VSYS_BIT    = 2;
    localparam int SRC_BAT_BIT     = 1;
    localparam int SRC_ADAPTER_BIT = 0;
    localparam int SRC_COUNT       = 7;

    // threshold/deglitch field layout
    localparam int THR_MSB    = 7;
    localparam int THR_LSB    = 2;
    localparam int DEG_MSB    = 1;
    localparam int DEG_LSB    = 0;
    localparam int STEP_SHIFT = 9;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEG_00_NS     = 1600000;
    localparam int DEG_01_NS     = 100000;
    localparam int DEG_10_NS     = 6000000;
    localparam int DEG_11_NS     = 12000000;
    localparam int CNT_W         = 21;
    localparam logic [CNT_W-1:0] DEG_00_CYC = CNT_W'(DEG_00_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DEG_01_CYC = CNT_W'(DEG_01_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DEG_10_CYC = CNT_W'(DEG_10_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DEG_11_CYC = CNT_W'(DEG_11_NS / CLK_PERIOD_NS);

    // two-wire port target address; value is arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

endpackage
`default_nettype wire

// file: hdl/deglitch_filter.sv
// deglitch filter: output rises after the input stays high for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module deglitch_filter
    import throttle_alert_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clkEn,
    // condition in and out
    input  wire logic         rawIn,
    input  wire logic [W-1:0] limit,
    output logic              filtOut
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         out_r;
    logic         out_nxt;

    // release is immediate; only the assert edge is filtered
    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        if (!rawIn) begin
            cnt_nxt = '0;
            out_nxt = 1'b0;
        end else if (!out_r) begin
            if (cnt_r >= limit - W'(1)) begin
                out_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else if (clkEn) begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign filtOut = out_r;

    AST_DEG_RISE: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && rawIn && !out_r && cnt_r >= limit - W'(1)) |=> out_r)
        else $error("filter did not assert after its hold time");

    AST_DEG_EARLY: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && !out_r && cnt_r < limit - W'(1)) |=> !out_r)
        else $error("filter asserted before its hold time");

    AST_DEG_DROP: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && !rawIn) |=> !out_r)
        else $error("filter output did not release");
endmodule // deglitch_filter
`default_nettype wire

// file: hdl/throttle_alert_profile_config.sv
// throttle alert profile: two-wire register port, source gating and alert drive
`timescale 1ns/1ps
`default_nettype none
module throttle_alert_profile_config
    import throttle_alert_pkg::*;
#(
    parameter logic [6:0]       DEV_ADDR    = DEV_ADDR_DEFAULT,
    parameter logic [CNT_W-1:0] DEG0_CYCLES = DEG_00_CYC,
    parameter logic [CNT_W-1:0] DEG1_CYCLES = DEG_01_CYC,
    parameter logic [CNT_W-1:0] DEG2_CYCLES = DEG_10_CYC,
    parameter logic [CNT_W-1:0] DEG3_CYCLES = DEG_11_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // two-wire register port
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    // monitored conditions
    input  wire logic [15:0] dischargeMa,
    input  wire logic        comparatorTrip,
    input  wire logic        criticalCurrentTrip,
    input  wire logic        nominalCurrentTrip,
    input  wire logic        systemVoltageLow,
    input  wire logic        batteryPresent,
    input  wire logic        adapterPresent,
    // open-drain alert to the processor
    output logic             throttleAlertOut,
    output logic             throttleAlertOe
);
    typedef enum {
        S_IDLE, S_ADDR, S_ACK_ADDR, S_PTR, S_ACK_PTR, S_WR, S_ACK_WR, S_RD, S_ACK_RD
    } i2c_state_t;

    function automatic logic [7:0] regRead(input logic [7:0] a, input logic [7:0] e,
                                           input logic [7:0] t);
        if (a == REG_SRC_EN_ADDR) begin
            return e;
        end else if (a == REG_THR_DEG_ADDR) begin
            return t;
        end
        return 8'h00;
    endfunction

    function automatic logic [15:0] thresholdMa(input logic [5:0] code);
        return {1'b0, code, 9'h000};
    endfunction

    function automatic logic [CNT_W-1:0] degCycles(input logic [1:0] sel);
        case (sel)
            2'h0:    return DEG0_CYCLES;
            2'h1:    return DEG1_CYCLES;
            2'h2:    return DEG2_CYCLES;
            default: return DEG3_CYCLES;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: 0 scl, 1 sda, 2 comp, 3 crit, 4 nom, 5 vsys, 6 bat, 7 adapter
    logic [7:0] pinMeta_r;
    logic [7:0] pinSync_r;
    logic [1:0] busPrev_r;
    logic [7:0] pinRaw;
    logic       sclS;
    logic       sdaS;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;

    assign pinRaw = {adapterPresent, batteryPresent, systemVoltageLow, nominalCurrentTrip,
                     criticalCurrentTrip, comparatorTrip, sdaIn, sclIn};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinMeta_r <= 8'hC3;
            pinSync_r <= 8'hC3;
            busPrev_r <= 2'h3;
        end else if (clkEn) begin
            pinMeta_r <= pinRaw;
            pinSync_r <= pinMeta_r;
            busPrev_r <= pinSync_r[1:0];
        end
    end

    assign sclS      = pinSync_r[0];
    assign sdaS      = pinSync_r[1];
    assign sclRise   = sclS && !busPrev_r[0];
    assign sclFall   = !sclS && busPrev_r[0];
    assign startCond = sclS && busPrev_r[0] && busPrev_r[1] && !sdaS;
    assign stopCond  = sclS && busPrev_r[0] && !busPrev_r[1] && sdaS;

    ////////////////////////////////////////////////////////////////////////////////
    // two-wire target and the two registers
    i2c_state_t st_r;
    i2c_state_t st_nxt;
    logic [3:0] bitCnt_r;
    logic [3:0] bitCnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic       isRead_r;
    logic       isRead_nxt;
    logic       sdaOe_r;
    logic       sdaOe_nxt;
    logic [7:0] srcEn_r;
    logic [7:0] srcEn_nxt;
    logic [7:0] thrDeg_r;
    logic [7:0] thrDeg_nxt;

    always_comb begin
        logic [7:0] rdByte;
        logic [7:0] rdNext;
        rdByte     = regRead(ptr_r, srcEn_r, thrDeg_r);
        rdNext     = regRead(ptr_r + 8'h01, srcEn_r, thrDeg_r);
        st_nxt     = st_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt  = shift_r;
        ptr_nxt    = ptr_r;
        isRead_nxt = isRead_r;
        sdaOe_nxt  = sdaOe_r;
        srcEn_nxt  = srcEn_r;
        thrDeg_nxt = thrDeg_r;
        if (startCond) begin
            st_nxt     = S_ADDR;
            bitCnt_nxt = 4'h0;
            sdaOe_nxt  = 1'b0;
        end else if (stopCond) begin
            st_nxt    = S_IDLE;
            sdaOe_nxt = 1'b0;
        end else begin
            case (st_r)
                S_ADDR, S_PTR, S_WR: begin
                    if (sclRise) begin
                        shift_nxt  = {shift_r[6:0], sdaS};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == 4'h8) begin
                        bitCnt_nxt = 4'h0;
                        sdaOe_nxt  = 1'b1;
                        if (st_r == S_ADDR) begin
                            isRead_nxt = shift_r[0];
                            st_nxt     = S_ACK_ADDR;
                            if (shift_r[7:1] != DEV_ADDR) begin
                                st_nxt    = S_IDLE;
                                sdaOe_nxt = 1'b0;
                            end
                        end else if (st_r == S_PTR) begin
                            ptr_nxt = shift_r;
                            st_nxt  = S_ACK_PTR;
                        end else begin
                            // writes to unmapped addresses are acknowledged and dropped
                            if (ptr_r == REG_SRC_EN_ADDR) begin
                                srcEn_nxt = shift_r;
                            end
                            if (ptr_r == REG_THR_DEG_ADDR) begin
                                thrDeg_nxt = shift_r;
                            end
                            ptr_nxt = ptr_r + 8'h01;
                            st_nxt  = S_ACK_WR;
                        end
                    end
                end
                S_ACK_ADDR, S_ACK_PTR, S_ACK_WR: begin
                    if (sclFall) begin
                        sdaOe_nxt = 1'b0;
                        st_nxt    = (st_r == S_ACK_ADDR) ? S_PTR : S_WR;
                        if (st_r == S_ACK_ADDR && isRead_r) begin
                            st_nxt    = S_RD;
                            shift_nxt = rdByte;
                            sdaOe_nxt = !rdByte[7];
                        end
                    end
                end
                S_RD: begin
                    if (sclFall) begin
                        if (bitCnt_r == 4'h7) begin
                            bitCnt_nxt = 4'h0;
                            sdaOe_nxt  = 1'b0;
                            st_nxt     = S_ACK_RD;
                        end else begin
                            shift_nxt  = {shift_r[6:0], 1'b0};
                            sdaOe_nxt  = !shift_r[6];
                            bitCnt_nxt = bitCnt_r + 4'h1;
                        end
                    end
                end
                S_ACK_RD: begin
                    if (sclRise && sdaS) begin
                        st_nxt = S_IDLE;
                    end else if (sclFall) begin
                        ptr_nxt   = ptr_r + 8'h01;
                        shift_nxt = rdNext;
                        sdaOe_nxt = !rdNext[7];
                        st_nxt    = S_RD;
                    end
                end
                default: begin
                    sdaOe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r     <= S_IDLE;
            bitCnt_r <= 4'h0;
            shift_r  <= 8'h00;
            ptr_r    <= 8'h00;
            isRead_r <= 1'b0;
            sdaOe_r  <= 1'b0;
            srcEn_r  <= SRC_EN_RESET;
            thrDeg_r <= THR_DEG_RESET;
        end else if (clkEn) begin
            st_r     <= st_nxt;
            bitCnt_r <= bitCnt_nxt;
            shift_r  <= shift_nxt;
            ptr_r    <= ptr_nxt;
            isRead_r <= isRead_nxt;
            sdaOe_r  <= sdaOe_nxt;
            srcEn_r  <= srcEn_nxt;
            thrDeg_r <= thrDeg_nxt;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // source conditions and alert drive
    logic [5:0]           thrCode;
    logic                 dischargeRaw;
    logic                 dischargeFilt;
    logic [SRC_COUNT-1:0] srcCond;
    logic                 functionOn;
    logic                 alertReq;
    logic                 batPrev_r;
    logic                 batPrev_nxt;
    logic                 batPulse_r;
    logic                 batPulse_nxt;
    logic                 alertOe_r;
    logic                 alertOe_nxt;

    assign thrCode      = thrDeg_r[THR_MSB:THR_LSB];
    // zero code trips unconditionally, even at zero current
    assign dischargeRaw = (thrCode == 6'h00)
                       || (dischargeMa > thresholdMa(thrCode));

    deglitch_filter #(
        .W (CNT_W)
    ) u_dchg_filter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .rawIn   (dischargeRaw),
        .limit   (degCycles(thrDeg_r[DEG_MSB:DEG_LSB])),
        .filtOut (dischargeFilt)
    );

    // the analog trips arrive already filtered by their own comparators
    always_comb begin
        srcCond                  = '0;
        srcCond[SRC_COMP_BIT]    = pinSync_r[2];
        srcCond[SRC_CRIT_BIT]    = pinSync_r[3];
        srcCond[SRC_NOM_BIT]     = pinSync_r[4];
        srcCond[SRC_DCHG_BIT]    = dischargeFilt;
        srcCond[SRC_VSYS_BIT]    = pinSync_r[5];
        srcCond[SRC_BAT_BIT]     = batPulse_r;
        srcCond[SRC_ADAPTER_BIT] = !pinSync_r[7];
        functionOn               = |srcEn_r[SRC_COUNT-1:0];
        alertReq                 = functionOn && |(srcCond & srcEn_r[SRC_COUNT-1:0]);
        batPrev_nxt              = pinSync_r[6];
        batPulse_nxt             = srcEn_r[SRC_BAT_BIT] && batPrev_r && !pinSync_r[6];
        alertOe_nxt              = alertReq;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            batPrev_r  <= 1'b1;
            batPulse_r <= 1'b0;
            alertOe_r  <= 1'b0;
        end else if (clkEn) begin
            batPrev_r  <= batPrev_nxt;
            batPulse_r <= batPulse_nxt;
            alertOe_r  <= alertOe_nxt;
        end
    end

    assign throttleAlertOut = 1'b0;
    assign throttleAlertOe  = alertOe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence batFallSeq;
        clkEn && srcEn_r[SRC_BAT_BIT] && batPrev_r && !pinSync_r[6];
    endsequence

    sequence batPulseSeq;
        batPulse_r ##1 !batPulse_r;
    endsequence

    AST_BAT_ONESHOT: assert property (@(posedge sys_clk) disable iff (rst)
        batFallSeq |=> batPulseSeq)
        else $error("battery removal did not give a single pulse");

    AST_BAT_ALERT: assert property (@(posedge sys_clk) disable iff (rst)
        batFallSeq ##1 clkEn |=> throttleAlertOe)
        else $error("battery pulse did not reach the alert");

    AST_ALL_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && srcEn_r[SRC_COUNT-1:0] == 7'h00) |=> !throttleAlertOe)
        else $error("alert driven with every source disabled");

    AST_COMP_SRC: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && srcEn_r[SRC_COMP_BIT] && pinSync_r[2]) |=> throttleAlertOe)
        else $error("comparator source did not raise the alert");

    AST_ADAPTER_SRC: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && srcEn_r[SRC_ADAPTER_BIT] && !pinSync_r[7]) |=> throttleAlertOe)
        else $error("adapter removal did not raise the alert");

    AST_BLOCKED: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && (srcCond & srcEn_r[SRC_COUNT-1:0]) == 7'h00) |=> !throttleAlertOe)
        else $error("alert driven without an enabled active source");

    AST_ZERO_CODE: assert property (@(posedge sys_clk) disable iff (rst)
        (thrCode == 6'h00) |-> dischargeRaw)
        else $error("zero threshold did not trip the discharge condition");

    AST_THR_STEP: assert property (@(posedge sys_clk) disable iff (rst)
        (thrCode != 6'h00 && dischargeMa <= 16'(thrCode) * 16'd512) |-> !dischargeRaw)
        else $error("discharge tripped at or below its threshold");

    AST_DCHG_ALERT: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && srcEn_r[SRC_DCHG_BIT] && dischargeFilt) |=> throttleAlertOe)
        else $error("filtered discharge did not raise the alert");
endmodule // throttle_alert_profile_config
`default_nettype wire

// file: verification/two_wire_host_model.sv
// two-wire host model: byte level master on the register port
`timescale 1ns/1ps
`default_nettype none
module two_wire_host_model #(
    parameter int HALF = 6
) (
    // clock
    input  wire logic sys_clk,
    // bus pins
    input  wire logic sdaLine,
    output var logic  sclOut,
    output var logic  sdaLow
);
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic hw();
        repeat (HALF) @(posedge sys_clk);
    endtask

    // works from idle and as a repeated start from scl low
    task automatic start();
        sdaLow <= 1'b0;
        hw();
        sclOut <= 1'b1;
        hw();
        sdaLow <= 1'b1;
        hw();
        sclOut <= 1'b0;
    endtask

    // sda moves two cycles after scl falls so the synced pins never change together
    task automatic bitx(input logic b, output logic s);
        repeat (2) @(posedge sys_clk);
        sdaLow <= !b;
        hw();
        sclOut <= 1'b1;
        hw();
        s = sdaLine;
        sclOut <= 1'b0;
    endtask

    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
        end
        bitx(1'b1, s);
        ack = !s;
    endtask

    task automatic rdByte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(nack, s);
    endtask

    task automatic stop();
        repeat (2) @(posedge sys_clk);
        sdaLow <= 1'b1;
        hw();
        sclOut <= 1'b1;
        hw();
        sdaLow <= 1'b0;
        hw();
    endtask
endmodule // two_wire_host_model
`default_nettype wire

// file: verification/throttle_alert_profile_config_tb.sv
// testbench: register access, source gating and alert timing
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module throttle_alert_profile_config_tb;
    import throttle_alert_pkg::*;
    localparam int DG [4] = '{8, 4, 12, 16};
    localparam int SB [4] = '{SRC_COMP_BIT, SRC_CRIT_BIT, SRC_NOM_BIT, SRC_VSYS_BIT};
    logic        sys_clk;
    logic        rst;
    logic        clkEn;
    logic [15:0] dischargeMa;
    logic [3:0]  trip;
    logic        bat;
    logic        adp;
    wire logic   scl;
    wire logic   sdaLow;
    wire logic   sdaOe;
    wire logic   alertOe;
    wire logic   sdaOut;
    wire logic   alertOut;
    wire logic   sdaLine = !(sdaOe | sdaLow);
    int          num_errors = 0;
    int          tests_run = 0;
    int          hiCnt = 0;

    throttle_alert_profile_config #(
        .DEG0_CYCLES(CNT_W'(DG[0])), .DEG1_CYCLES(CNT_W'(DG[1])),
        .DEG2_CYCLES(CNT_W'(DG[2])), .DEG3_CYCLES(CNT_W'(DG[3]))
    ) i_throttle_alert_profile_config (
        .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .dischargeMa(dischargeMa), .comparatorTrip(trip[0]),
        .criticalCurrentTrip(trip[1]), .nominalCurrentTrip(trip[2]),
        .systemVoltageLow(trip[3]), .batteryPresent(bat), .adapterPresent(adp),
        .throttleAlertOut(alertOut), .throttleAlertOe(alertOe)
    );
    two_wire_host_model i_two_wire_host_model (
        .sys_clk(sys_clk), .sdaLine(sdaLine), .sclOut(scl), .sdaLow(sdaLow)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    // alert cycles counted on the same edge the design registers them; an unknown counts too
    always @(posedge sys_clk) begin
        if (alertOe !== 1'b0) hiCnt++;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        logic [2:0] k;
        i_two_wire_host_model.start();
        i_two_wire_host_model.wrByte({DEV_ADDR_DEFAULT, 1'b0}, k[2]);
        i_two_wire_host_model.wrByte(a, k[1]);
        i_two_wire_host_model.wrByte(d, k[0]);
        i_two_wire_host_model.stop();
        `CHK("write ack", 3'h7, k)
    endtask
    task automatic regRd(input logic [7:0] a, output logic [7:0] d);
        logic [2:0] k;
        i_two_wire_host_model.start();
        i_two_wire_host_model.wrByte({DEV_ADDR_DEFAULT, 1'b0}, k[2]);
        i_two_wire_host_model.wrByte(a, k[1]);
        i_two_wire_host_model.start();
        i_two_wire_host_model.wrByte({DEV_ADDR_DEFAULT, 1'b1}, k[0]);
        i_two_wire_host_model.rdByte(1'b1, d);
        i_two_wire_host_model.stop();
        `CHK("read ack", 3'h7, k)
    endtask
    // current just at the threshold stays quiet, one above trips after the deglitch span
    task automatic dchk(input logic [5:0] code, input logic [1:0] sel, input logic [15:0] ma);
        int n;
        regWr(REG_THR_DEG_ADDR, {code, sel});
        @(posedge sys_clk);
        dischargeMa <= ma;
        cyc(40);
        hiCnt = 0;
        cyc(20);
        `CHK("at threshold", 0, hiCnt)
        @(posedge sys_clk);
        dischargeMa <= ma + 16'h0001;
        n = 0;
        while (alertOe !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        `CHK("deglitch span", 1'b1, n >= DG[sel] && n <= DG[sel] + 3)
        @(posedge sys_clk);
        dischargeMa <= 16'h0000;
        cyc(6);
        `CHK("discharge released", 1'b0, alertOe)
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        close_out();
    end

    initial begin
        logic [7:0] d;
        logic       k;
        int         n;
        rst = 1'b1;
        clkEn = 1'b1;
        dischargeMa = 16'h0000;
        trip = 4'h0;
        bat = 1'b1;
        adp = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(4);
        regRd(REG_SRC_EN_ADDR, d);
        `CHK("source enable reset", 8'h20, d)
        regRd(REG_THR_DEG_ADDR, d);
        `CHK("threshold reset", 8'h81, d)
        `CHK("alert idle", 1'b0, alertOe)
        `CHK("data pin level", 1'b0, sdaOut)
        regWr(8'h3A, 8'h5A);
        regRd(8'h3A, d);
        `CHK("unmapped read", 8'h00, d)
        i_two_wire_host_model.start();
        i_two_wire_host_model.wrByte({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, k);
        i_two_wire_host_model.stop();
        `CHK("foreign address nack", 1'b0, k)
        // every condition active with every enable clear
        regWr(REG_SRC_EN_ADDR, 8'h00);
        @(posedge sys_clk);
        trip <= 4'hF;
        adp <= 1'b0;
        bat <= 1'b0;
        dischargeMa <= 16'hFFFF;
        cyc(2);
        hiCnt = 0;
        cyc(40);
        `CHK("function off", 0, hiCnt)
        @(posedge sys_clk);
        trip <= 4'h0;
        adp <= 1'b1;
        bat <= 1'b1;
        dischargeMa <= 16'h0000;
        for (int i = 0; i < 4; i++) begin
            regWr(REG_SRC_EN_ADDR, 8'h01 << SB[i]);
            @(posedge sys_clk);
            trip <= ~(4'h1 << i);
            cyc(8);
            `CHK("other sources blocked", 1'b0, alertOe)
            @(posedge sys_clk);
            trip <= 4'hF;
            cyc(6);
            `CHK("source passes", 1'b1, alertOe)
            @(posedge sys_clk);
            trip <= 4'h0;
            cyc(6);
            `CHK("source released", 1'b0, alertOe)
        end
        regWr(REG_SRC_EN_ADDR, 8'h01);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        adp <= 1'b0;
        cyc(6);
        `CHK("frozen while disabled", 1'b0, alertOe)
        @(posedge sys_clk);
        clkEn <= 1'b1;
        cyc(6);
        `CHK("adapter removed", 1'b1, alertOe)
        `CHK("alert pin level", 1'b0, alertOut)
        @(posedge sys_clk);
        adp <= 1'b1;
        cyc(6);
        `CHK("adapter back", 1'b0, alertOe)
        regWr(REG_SRC_EN_ADDR, 8'h02);
        hiCnt = 0;
        @(posedge sys_clk);
        bat <= 1'b0;
        cyc(20);
        `CHK("battery one pulse", 1, hiCnt)
        @(posedge sys_clk);
        bat <= 1'b1;
        cyc(20);
        `CHK("battery insert quiet", 1, hiCnt)
        regWr(REG_SRC_EN_ADDR, 8'h08);
        for (int s = 0; s < 4; s++) begin
            dchk(6'h02, 2'(s), 16'h0400);
        end
        dchk(6'h3F, 2'h1, 16'h7E00);
        // code zero trips with no current at all
        regWr(REG_THR_DEG_ADDR, 8'h01);
        n = 0;
        while (alertOe !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        `CHK("zero code trips", 1'b1, alertOe)
        close_out();
    end
endmodule // throttle_alert_profile_config_tb
`default_nettype wire
